// ---- src/ufsr_pkg.sv ----
// Shared constants and types of the UART FIFO and status register block.
// Assumes one 100 MHz clock and a byte-wide register port.
package ufsr_pkg;

    // ************************************************************
    // Register offsets
    // ************************************************************
    localparam logic [8:0] OFS_SPECIAL_FUNC   = 9'h007;
    localparam logic [8:0] OFS_RX_LS_COUNT    = 9'h015;
    localparam logic [8:0] OFS_TX_SC          = 9'h016;
    localparam logic [8:0] OFS_GLOBAL_STATUS  = 9'h017;
    localparam logic [8:0] OFS_IRQ_STATUS     = 9'h018;
    localparam logic [8:0] OFS_IRQ_MASK       = 9'h019;
    localparam logic [8:0] OFS_RX_WIN_LO      = 9'h100;
    localparam logic [8:0] OFS_RX_WIN_HI      = 9'h17F;
    localparam logic [8:0] OFS_LS_WIN_LO      = 9'h180;
    localparam logic [8:0] OFS_LS_WIN_HI      = 9'h1FF;

    // ************************************************************
    // Field positions
    // ************************************************************
    localparam int SEL_RX_COUNT_BIT = 6;
    localparam int SEL_TX_COUNT_BIT = 7;
    localparam int GLS_RX_AVAIL     = 0;
    localparam int GLS_OVERRUN      = 1;
    localparam int GLS_PARITY       = 2;
    localparam int GLS_FRAME        = 3;
    localparam int GLS_BREAK        = 4;
    localparam int GLS_THR_EMPTY    = 5;
    localparam int GLS_TSR_EMPTY    = 6;
    localparam int GLS_RX_ERROR     = 7;
    localparam int IRQ_RX_ARRIVED   = 0;
    localparam int IRQ_OVERRUN      = 1;
    localparam int IRQ_RX_BAD_BYTE  = 2;
    localparam int IRQ_TX_DRAINED   = 3;
    localparam int IRQ_TX_DROPPED   = 4;
    localparam int IRQ_BITS         = 5;

    // ************************************************************
    // Sizes, reset values and sample clock coding
    // ************************************************************
    localparam int         FIFO_DEPTH   = 128;
    localparam int         PTR_W        = 7;
    localparam logic [7:0] COUNT_RESET  = 8'h00;
    localparam logic [7:0] COUNT_FULL   = 8'h80;
    localparam logic [7:0] BYTE_RESET   = 8'h00;
    localparam logic [3:0] SC_RESET     = 4'h0;
    localparam logic [3:0] SC_CODE_MAX  = 4'hC;
    localparam logic [4:0] SC_AT_ZERO   = 5'h10;
    localparam logic [4:0] SC_LEAST     = 5'h04;

    // Error flags carried beside each received byte
    typedef struct packed {
        logic brk;
        logic frame;
        logic parity;
    } ufsr_rx_err_t;

    typedef struct packed {
        ufsr_rx_err_t err;
        logic [7:0]   data;
    } ufsr_rx_entry_t;

endpackage : ufsr_pkg

// ---- src/ufsr_regs.sv ----
// UART FIFO counters, sample clock, global line status and FIFO windows.
// Assumes the receiver pushes bytes and the transmitter pops bytes on
// ref_clk_i; the register port is driven synchronously on the same clock.
//
// How it works
// [R1] 15h reads rx count if select bit6
// [R2] Rx FIFO fill count, read-only, resets zero
// [R3] Line-status FIFO count, read-only, resets zero
// [R4] 16h is tx count if select bit7
// [R5] Tx FIFO fill count, read-only, resets zero
// [R6] Sample code 0..12 gives 16 down to 4
// [R7] Status bit0: receive FIFO not empty
// [R8] Status bit1: receive overrun occurred
// [R9] Status bits2-4: parity, framing, break
// [R10] Status bit5: transmit holding register empty
// [R11] Status bit6: transmit shift register empty
// [R12] Status bit7: any receive FIFO error
// [R13] Reads 100h-17Fh return receive data
// [R14] Writes 100h-17Fh push transmit FIFO
// [R15] Reads 180h-1FFh return line-status entry
// [R16] Rx window read pops; tx write counts
`timescale 1ns/1ps

module ufsr_regs (
    input  wire logic                     ref_clk_i,
    input  wire logic                     rst_n_i,
    // Register port
    input  wire logic [8:0]               reg_addr_i,
    input  wire logic [7:0]               reg_wdata_i,
    input  wire logic                     reg_wr_i,
    input  wire logic                     reg_rd_i,
    output logic      [7:0]               reg_rdata_o,
    // Receiver side
    input  wire logic                     rx_push_i,
    input  wire ufsr_pkg::ufsr_rx_entry_t rx_entry_i,
    // Transmitter side
    input  wire logic                     tx_pop_i,
    output logic                          tx_valid_o,
    output logic      [7:0]               tx_data_o,
    input  wire logic                     tx_shift_empty_i,
    // Baud generator and interrupt
    output logic      [4:0]               sample_clock_divisor_value_o,
    output logic                          irq_o
);

    localparam int PTR_W_L = ufsr_pkg::PTR_W;

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic logic in_range(input logic [8:0] a,
                                      input logic [8:0] lo,
                                      input logic [8:0] hi);
        in_range = (a >= lo) && (a <= hi);
    endfunction : in_range

    function automatic logic [PTR_W_L-1:0] ptr_inc(
        input logic [PTR_W_L-1:0] p);
        ptr_inc = p + 1'b1;
    endfunction : ptr_inc

    // Reserved codes clamp to 4 samples
    function automatic logic [4:0] sc_value(input logic [3:0] code);
        if (code > ufsr_pkg::SC_CODE_MAX) begin
            sc_value = ufsr_pkg::SC_LEAST;
        end else begin
            sc_value = ufsr_pkg::SC_AT_ZERO - {1'b0, code};
        end
    endfunction : sc_value
    // ************************************************************
    // Storage
    // ************************************************************
    ufsr_pkg::ufsr_rx_entry_t rx_mem [ufsr_pkg::FIFO_DEPTH];
    logic [7:0]               tx_mem [ufsr_pkg::FIFO_DEPTH];

    logic [PTR_W_L-1:0] rx_wr_ptr_reg;
    logic [PTR_W_L-1:0] rx_rd_ptr_reg;
    logic [7:0]         rx_count_reg;
    logic [7:0]         ls_count_reg;
    logic [7:0]         err_count_reg;
    logic [PTR_W_L-1:0] tx_wr_ptr_reg;
    logic [PTR_W_L-1:0] tx_rd_ptr_reg;
    logic [7:0]         tx_count_reg;
    logic [7:0]         select_reg;
    logic [3:0]         sc_code_reg;
    logic               overrun_reg;
    logic               thr_empty_reg;
    logic               tsr_empty_reg;
    logic [ufsr_pkg::IRQ_BITS-1:0] irq_status_reg;
    logic [ufsr_pkg::IRQ_BITS-1:0] irq_status_next;
    logic [ufsr_pkg::IRQ_BITS-1:0] irq_mask_reg;
    logic [7:0]         rdata_reg;
    logic [7:0]         rdata_next;

    // ************************************************************
    // Address decode
    // ************************************************************
    wire logic hit_select  = (reg_addr_i == ufsr_pkg::OFS_SPECIAL_FUNC);
    wire logic hit_rx_ls   = (reg_addr_i == ufsr_pkg::OFS_RX_LS_COUNT);
    wire logic hit_tx_sc   = (reg_addr_i == ufsr_pkg::OFS_TX_SC);
    wire logic hit_gls     = (reg_addr_i == ufsr_pkg::OFS_GLOBAL_STATUS);
    wire logic hit_ist     = (reg_addr_i == ufsr_pkg::OFS_IRQ_STATUS);
    wire logic hit_imask   = (reg_addr_i == ufsr_pkg::OFS_IRQ_MASK);
    wire logic hit_data    = in_range(reg_addr_i, ufsr_pkg::OFS_RX_WIN_LO,
                                      ufsr_pkg::OFS_RX_WIN_HI);
    wire logic hit_ls      = in_range(reg_addr_i, ufsr_pkg::OFS_LS_WIN_LO,
                                      ufsr_pkg::OFS_LS_WIN_HI);

    wire logic sel_rx_cnt  = select_reg[ufsr_pkg::SEL_RX_COUNT_BIT];
    wire logic sel_tx_cnt  = select_reg[ufsr_pkg::SEL_TX_COUNT_BIT];

    // ************************************************************
    // FIFO control
    // ************************************************************
    wire logic rx_empty    = (rx_count_reg == ufsr_pkg::COUNT_RESET);
    wire logic rx_full     = (rx_count_reg == ufsr_pkg::COUNT_FULL);
    wire logic tx_empty    = (tx_count_reg == ufsr_pkg::COUNT_RESET);
    wire logic tx_full     = (tx_count_reg == ufsr_pkg::COUNT_FULL);

    // Rx window read with data pops [R16]
    wire logic rx_pop      = reg_rd_i && hit_data && !rx_empty;
    // Push into full FIFO is lost unless a window read pops in the same cycle
    wire logic rx_take     = rx_push_i && (!rx_full || rx_pop);
    wire logic rx_lost     = rx_push_i && !rx_take;
    wire logic in_bad      = |rx_entry_i.err;

    wire ufsr_pkg::ufsr_rx_entry_t rx_head = rx_mem[rx_rd_ptr_reg];
    wire logic head_bad    = !rx_empty && (|rx_head.err);

    wire logic tx_write    = reg_wr_i && hit_data;
    wire logic tx_do_pop   = tx_pop_i && !tx_empty;
    wire logic tx_take     = tx_write && (!tx_full || tx_do_pop);
    wire logic tx_dropped  = tx_write && !tx_take;

    // ************************************************************
    // Status assembly
    // ************************************************************
    wire logic [7:0] ls_entry_byte = {3'b000, rx_head.err.brk,
                                      rx_head.err.frame,
                                      rx_head.err.parity, 2'b00};
    wire logic [7:0] line_status_entry =
        rx_empty ? ufsr_pkg::BYTE_RESET : ls_entry_byte;

    wire logic [7:0] global_status = {
        (err_count_reg != ufsr_pkg::COUNT_RESET),       // [R12]
        tsr_empty_reg,                                   // [R11]
        thr_empty_reg,                                   // [R10]
        head_bad && rx_head.err.brk,                     // [R9]
        head_bad && rx_head.err.frame,                   // [R9]
        head_bad && rx_head.err.parity,                  // [R9]
        overrun_reg,                                     // [R8]
        !rx_empty                                        // [R7]
    };

    wire logic [7:0] rx_ls_view =
        sel_rx_cnt ? rx_count_reg : ls_count_reg;        // [R1]
    wire logic [7:0] tx_sc_view =
        sel_tx_cnt ? tx_count_reg                        // [R4]
                   : {4'h0, sc_code_reg};                // [R6]

    // ************************************************************
    // Read data mux, answered one cycle after the strobe
    // ************************************************************
    always_comb begin
        rdata_next = ufsr_pkg::BYTE_RESET;
        if (!reg_rd_i) begin
            rdata_next = ufsr_pkg::BYTE_RESET;
        end else if (hit_select) begin
            rdata_next = select_reg;
        end else if (hit_rx_ls) begin
            rdata_next = rx_ls_view;
        end else if (hit_tx_sc) begin
            rdata_next = tx_sc_view;
        end else if (hit_gls) begin
            rdata_next = global_status;
        end else if (hit_ist) begin
            rdata_next = {3'b000, irq_status_reg};
        end else if (hit_imask) begin
            rdata_next = {3'b000, irq_mask_reg};
        end else if (hit_data) begin
            rdata_next = rx_empty ? ufsr_pkg::BYTE_RESET
                                  : rx_head.data;        // [R13]
        end else if (hit_ls) begin
            rdata_next = line_status_entry;              // [R15]
        end
    end

    // ************************************************************
    // Interrupt status: set wins over write-one-clear
    // ************************************************************
    wire logic [ufsr_pkg::IRQ_BITS-1:0] irq_events = {
        tx_dropped,
        tx_do_pop && (tx_count_reg == 8'h01) && !tx_take,
        rx_take && in_bad,
        rx_lost,
        rx_take
    };
    wire logic [ufsr_pkg::IRQ_BITS-1:0] irq_clear =
        (reg_wr_i && hit_ist) ? reg_wdata_i[ufsr_pkg::IRQ_BITS-1:0]
                              : '0;

    always_comb begin
        irq_status_next = (irq_status_reg & ~irq_clear) | irq_events;
    end

    assign irq_o = |(irq_status_reg & irq_mask_reg);

    // ************************************************************
    // Receive FIFO
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (rx_take) begin
            rx_mem[rx_wr_ptr_reg] <= rx_entry_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_wr_ptr_reg <= '0;
            rx_rd_ptr_reg <= '0;
        end else begin
            if (rx_take) begin
                rx_wr_ptr_reg <= ptr_inc(rx_wr_ptr_reg);
            end
            if (rx_pop) begin
                rx_rd_ptr_reg <= ptr_inc(rx_rd_ptr_reg);
            end
        end
    end

    // Entries travel together, so both counts match
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_count_reg <= ufsr_pkg::COUNT_RESET;       // [R2]
            ls_count_reg <= ufsr_pkg::COUNT_RESET;       // [R3]
        end else if (rx_take && !rx_pop) begin
            rx_count_reg <= rx_count_reg + 8'h01;        // [R2]
            ls_count_reg <= ls_count_reg + 8'h01;        // [R3]
        end else if (rx_pop && !rx_take) begin
            rx_count_reg <= rx_count_reg - 8'h01;        // [R16]
            ls_count_reg <= ls_count_reg - 8'h01;        // [R3]
        end
    end

    // Error entries still in the FIFO
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            err_count_reg <= ufsr_pkg::COUNT_RESET;
        end else begin
            case ({rx_take && in_bad, rx_pop && head_bad})
                2'b10:   err_count_reg <= err_count_reg + 8'h01; // [R12]
                2'b01:   err_count_reg <= err_count_reg - 8'h01; // [R12]
                default: err_count_reg <= err_count_reg;
            endcase
        end
    end

    // Overrun clears on status read; a new loss wins
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            overrun_reg <= 1'b0;
        end else if (rx_lost) begin
            overrun_reg <= 1'b1;                         // [R8]
        end else if (reg_rd_i && hit_gls) begin
            overrun_reg <= 1'b0;
        end
    end

    // ************************************************************
    // Transmit FIFO
    // ************************************************************
    always_ff @(posedge ref_clk_i) begin
        if (tx_take) begin
            tx_mem[tx_wr_ptr_reg] <= reg_wdata_i;        // [R14]
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_wr_ptr_reg <= '0;
            tx_rd_ptr_reg <= '0;
        end else begin
            if (tx_take) begin
                tx_wr_ptr_reg <= ptr_inc(tx_wr_ptr_reg);
            end
            if (tx_do_pop) begin
                tx_rd_ptr_reg <= ptr_inc(tx_rd_ptr_reg);
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_count_reg <= ufsr_pkg::COUNT_RESET;       // [R5]
        end else if (tx_take && !tx_do_pop) begin
            tx_count_reg <= tx_count_reg + 8'h01;        // [R16]
        end else if (tx_do_pop && !tx_take) begin
            tx_count_reg <= tx_count_reg - 8'h01;        // [R5]
        end
    end

    assign tx_valid_o = !tx_empty;
    assign tx_data_o  = tx_mem[tx_rd_ptr_reg];

    // Empty flags read zero out of reset
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            thr_empty_reg <= 1'b0;
            tsr_empty_reg <= 1'b0;
        end else begin
            thr_empty_reg <= tx_empty;                   // [R10]
            tsr_empty_reg <= tx_shift_empty_i;           // [R11]
        end
    end

    // ************************************************************
    // Software registers
    // ************************************************************
    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            select_reg   <= ufsr_pkg::BYTE_RESET;
            sc_code_reg  <= ufsr_pkg::SC_RESET;          // [R6]
            irq_mask_reg <= '0;
        end else if (reg_wr_i) begin
            if (hit_select) begin
                select_reg <= reg_wdata_i;
            end else if (hit_tx_sc && !sel_tx_cnt) begin
                sc_code_reg <= reg_wdata_i[3:0];         // [R6]
            end else if (hit_imask) begin
                irq_mask_reg <= reg_wdata_i[ufsr_pkg::IRQ_BITS-1:0];
            end
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            irq_status_reg <= '0;
            rdata_reg      <= ufsr_pkg::BYTE_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
            rdata_reg      <= rdata_next;
        end
    end

    assign reg_rdata_o = rdata_reg;
    assign sample_clock_divisor_value_o = sc_value(sc_code_reg); // [R6]

endmodule : ufsr_regs

// ---- test/ufsr_regs_assertions.sv ----
// Concurrent checks on the UART FIFO and status register block.
// Bound into ufsr_regs; sees only its ports.
`timescale 1ns/1ps

module ufsr_regs_assertions (
    input wire logic       ref_clk_i,
    input wire logic       rst_n_i,
    input wire logic [8:0] reg_addr_i,
    input wire logic [7:0] reg_wdata_i,
    input wire logic       reg_wr_i,
    input wire logic       reg_rd_i,
    input wire logic [7:0] reg_rdata_o,
    input wire logic       rx_push_i,
    input wire logic       tx_pop_i,
    input wire logic       tx_valid_o,
    input wire logic       tx_shift_empty_i,
    input wire logic [4:0] sample_clock_divisor_value_o
);
    // ************************************************************
    // Shadow state
    // ************************************************************
    logic [7:0] rx_cnt_reg;
    logic [7:0] sel_reg;
    logic       up_reg;
    wire  rx_win_rd = reg_rd_i && reg_addr_i[8:7] == 2'b10;
    wire  rx_pop    = rx_win_rd && rx_cnt_reg != 8'h00;
    wire  rx_take   = rx_push_i && (rx_cnt_reg != 8'h80 || rx_pop);

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rx_cnt_reg <= 8'h00;
            sel_reg    <= 8'h00;
            up_reg     <= 1'b0;
        end else begin
            rx_cnt_reg <= rx_cnt_reg + {7'h0, rx_take} - {7'h0, rx_pop};
            up_reg     <= 1'b1;
            if (reg_wr_i && reg_addr_i == ufsr_pkg::OFS_SPECIAL_FUNC) begin
                sel_reg <= reg_wdata_i;
            end
        end
    end

    // ************************************************************
    // Properties
    // ************************************************************
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!rst_n_i);

    sequence sc_write_s;
        reg_wr_i && reg_addr_i == ufsr_pkg::OFS_TX_SC && !sel_reg[7]
            && reg_wdata_i[3:0] <= ufsr_pkg::SC_CODE_MAX;
    endsequence
    sequence st_read_s;
        reg_rd_i && reg_addr_i == ufsr_pkg::OFS_GLOBAL_STATUS && up_reg;
    endsequence

    rdata_idle_a: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
        else $error("idle read data not zero");
    sc_map_a: assert property (sc_write_s |=>
        sample_clock_divisor_value_o == 5'h10 - {1'b0, $past(reg_wdata_i[3:0])})
        else $error("divisor wrong for code");
    rx_count_a: assert property (
        reg_rd_i && reg_addr_i == ufsr_pkg::OFS_RX_LS_COUNT
        |=> reg_rdata_o == $past(rx_cnt_reg))
        else $error("rx count read wrong");
    rx_avail_a: assert property (st_read_s |=>
        reg_rdata_o[0] == ($past(rx_cnt_reg) != 8'h00))
        else $error("rx avail bit wrong");
    rx_empty_rd_a: assert property (
        rx_win_rd && rx_cnt_reg == 8'h00 |=> reg_rdata_o == 8'h00)
        else $error("empty rx read not zero");
    tx_push_a: assert property (
        reg_wr_i && reg_addr_i[8:7] == 2'b10 && !tx_valid_o |=> tx_valid_o)
        else $error("tx write not queued");
    tx_drain_a: assert property ($fell(tx_valid_o) |-> $past(tx_pop_i))
        else $error("tx drained without pop");
    tx_empty_a: assert property (
        st_read_s ##0 tx_valid_o == $past(tx_valid_o)
        |=> reg_rdata_o[5] == !$past(tx_valid_o))
        else $error("thr empty bit wrong");
    shift_empty_a: assert property (
        st_read_s ##0 tx_shift_empty_i == $past(tx_shift_empty_i)
        |=> reg_rdata_o[6] == $past(tx_shift_empty_i))
        else $error("shift empty bit wrong");
endmodule : ufsr_regs_assertions

bind ufsr_regs ufsr_regs_assertions i_chk (
    .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i),
    .reg_rdata_o(reg_rdata_o), .rx_push_i(rx_push_i),
    .tx_pop_i(tx_pop_i), .tx_valid_o(tx_valid_o),
    .tx_shift_empty_i(tx_shift_empty_i),
    .sample_clock_divisor_value_o(sample_clock_divisor_value_o));

// ---- test/ufsr_line_model.sv ----
// Behavioural receiver and transmitter facing the FIFO block.
// Assumes the bench calls push and raises pop_en_i to let bytes drain.
`timescale 1ns/1ps

module ufsr_line_model (
    input  wire logic                ref_clk_i,
    input  wire logic                rst_n_i,
    input  wire logic                pop_en_i,
    input  wire logic                tx_valid_i,
    input  wire logic [7:0]          tx_data_i,
    output logic                     tx_pop_o,
    output logic                     tx_shift_empty_o,
    output logic                     rx_push_o,
    output ufsr_pkg::ufsr_rx_entry_t rx_entry_o
);
    logic [7:0] got [0:3];
    logic [1:0] n_got;
    logic [2:0] busy;

    // Shifter busy a few cycles per pop
    assign tx_shift_empty_o = busy == 3'h0 && !tx_pop_o;

    initial begin
        rx_push_o  = 1'b0;
        rx_entry_o = '0;
    end

    // Idle entry lines show the inverse, never a stale byte
    task automatic push(input logic [7:0] d, input logic [2:0] e);
        @(posedge ref_clk_i);
        rx_push_o  <= 1'b1;
        rx_entry_o <= ufsr_pkg::ufsr_rx_entry_t'({e, d});
        @(posedge ref_clk_i);
        rx_push_o  <= 1'b0;
        rx_entry_o <= ufsr_pkg::ufsr_rx_entry_t'(~{e, d});
    endtask : push

    always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            tx_pop_o <= 1'b0;
            busy     <= 3'h0;
            n_got    <= 2'h0;
        end else if (tx_pop_o) begin
            tx_pop_o     <= 1'b0;
            busy         <= 3'h4;
            got[n_got]   <= tx_data_i;
            n_got        <= n_got + 2'h1;
        end else if (busy != 3'h0) begin
            busy <= busy - 3'h1;
        end else if (pop_en_i && tx_valid_i) begin
            tx_pop_o <= 1'b1;
        end
    end
endmodule : ufsr_line_model

// ---- test/test_ufsr_regs.sv ----
// Self-checking bench for the UART FIFO and status register block.
// Assumes the bound checker and the line model.
`timescale 1ns/1ps

module test_ufsr_regs;
    logic                     ref_clk_i = 1'b0;
    logic                     rst_n_i = 1'b0;
    logic [8:0]               addr = 9'h000;
    logic [7:0]               wdata = 8'h00;
    logic                     wr_s = 1'b0;
    logic                     rd_s = 1'b0;
    logic                     pop_en = 1'b0;
    logic [7:0]               rdata;
    logic                     rx_push;
    logic                     tx_pop;
    logic                     tx_valid;
    logic                     shift_empty;
    logic                     irq;
    logic [7:0]               tx_data;
    logic [4:0]               divisor;
    ufsr_pkg::ufsr_rx_entry_t rx_entry;
    int                       n_fail = 0;
    int                       tests_run = 0;
    int                       cyc = 0;

    always #5 ref_clk_i = ~ref_clk_i;

    ufsr_regs i_dut (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(addr),
        .reg_wdata_i(wdata), .reg_wr_i(wr_s), .reg_rd_i(rd_s),
        .reg_rdata_o(rdata), .rx_push_i(rx_push), .rx_entry_i(rx_entry),
        .tx_pop_i(tx_pop), .tx_valid_o(tx_valid), .tx_data_o(tx_data),
        .tx_shift_empty_i(shift_empty),
        .sample_clock_divisor_value_o(divisor), .irq_o(irq));

    ufsr_line_model i_line (
        .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .pop_en_i(pop_en),
        .tx_valid_i(tx_valid), .tx_data_i(tx_data), .tx_pop_o(tx_pop),
        .tx_shift_empty_o(shift_empty), .rx_push_o(rx_push),
        .rx_entry_o(rx_entry));

    // ************************************************************
    // Bus and compare helpers
    // ************************************************************
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
            n_fail++;
        end
    endtask : check

    task automatic wr(input logic [8:0] a, input logic [7:0] d);
        @(posedge ref_clk_i);
        addr  <= a;
        wdata <= d;
        wr_s  <= 1'b1;
        @(posedge ref_clk_i);
        wr_s  <= 1'b0;
    endtask : wr

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [8:0] a, input logic [7:0] exp);
        @(posedge ref_clk_i);
        addr <= a;
        rd_s <= 1'b1;
        @(posedge ref_clk_i);
        rd_s <= 1'b0;
        #1 check(rdata, exp);
    endtask : rd

    // ************************************************************
    // Scenarios
    // ************************************************************
    task automatic t_reset();
        check({3'h0, divisor}, 8'h10);
        rd(9'h015, 8'h00);
        rd(9'h016, 8'h00);
        rd(9'h017, 8'h60);
        rd(9'h100, 8'h00);
        rd(9'h180, 8'h00);
        rd(9'h0FF, 8'h00);
        wr(9'h007, 8'h80);
        rd(9'h016, 8'h00);
        wr(9'h007, 8'h00);
        $display("t_reset done");
    endtask : t_reset

    task automatic t_sc();
        for (int c = 0; c <= 12; c++) begin
            wr(9'h016, 8'hF0 | 8'(c));
            rd(9'h016, 8'(c));
            check({3'h0, divisor}, 8'(16 - c));
        end
        wr(9'h016, 8'h00);
        $display("t_sc done");
    endtask : t_sc

    task automatic t_rx();
        i_line.push(8'hA1, 3'b000);
        i_line.push(8'hB2, 3'b001);
        i_line.push(8'hC3, 3'b110);
        wr(9'h007, 8'h40);
        rd(9'h015, 8'h03);
        wr(9'h007, 8'h00);
        rd(9'h015, 8'h03);
        rd(9'h017, 8'hE1);
        rd(9'h180, 8'h00);
        rd(9'h100, 8'hA1);
        rd(9'h180, 8'h04);
        rd(9'h15A, 8'hB2);
        rd(9'h1FF, 8'h18);
        rd(9'h017, 8'hF9);
        rd(9'h17F, 8'hC3);
        rd(9'h017, 8'h60);
        rd(9'h100, 8'h00);
        rd(9'h018, 8'h05);
        $display("t_rx done");
    endtask : t_rx

    task automatic t_over();
        wr(9'h018, 8'h1F);
        for (int i = 0; i <= 128; i++) i_line.push(8'(i), 3'b000);
        rd(9'h018, 8'h03);
        rd(9'h017, 8'h63);
        rd(9'h017, 8'h61);
        rd(9'h015, 8'h80);
        check({7'h0, irq}, 8'h00);
        wr(9'h019, 8'h02);
        @(posedge ref_clk_i);
        #1 check({7'h0, irq}, 8'h01);
        wr(9'h018, 8'h02);
        @(posedge ref_clk_i);
        #1 check({7'h0, irq}, 8'h00);
        wr(9'h019, 8'h00);
        for (int i = 0; i < 128; i++) rd(9'h100 + 9'(i), 8'(i));
        rd(9'h015, 8'h00);
        $display("t_over done");
    endtask : t_over

    task automatic t_tx();
        wr(9'h018, 8'h1F);
        wr(9'h007, 8'h80);
        wr(9'h100, 8'h5A);
        wr(9'h17F, 8'h3C);
        rd(9'h016, 8'h02);
        wr(9'h016, 8'h0C);
        check({3'h0, divisor}, 8'h10);
        rd(9'h017, 8'h40);
        pop_en <= 1'b1;
        for (int i = 0; i < 60 && tx_valid !== 1'b0; i++) begin
            @(posedge ref_clk_i);
        end
        check(i_line.got[0], 8'h5A);
        check(i_line.got[1], 8'h3C);
        rd(9'h016, 8'h00);
        rd(9'h018, 8'h08);
        wr(9'h007, 8'h00);
        $display("t_tx done");
    endtask : t_tx

    // ************************************************************
    // Run control
    // ************************************************************
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : wrap_up

    // Sequence needs about 700 cycles
    always @(posedge ref_clk_i) begin
        cyc++;
        if (cyc == 5000) begin
            n_fail++;
            wrap_up();
        end
    end

    initial begin
        repeat (2) @(posedge ref_clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_sc();
        t_rx();
        t_over();
        t_tx();
        wrap_up();
    end
endmodule : test_ufsr_regs
